// ===== inc/erc_pkg.sv
package erc_pkg;
   localparam int ERC_AW = 6;
   localparam int ERC_DW = 16;
   localparam int ERC_BEW = 2;
   localparam int ERC_DEPTH = 64;
   localparam int ERC_RAW = 2;
   localparam int ERC_CTRL_W = 10;

   // register indices on the plain register port
   localparam logic [ERC_RAW-1:0] ERC_REG_CTRL = 2'h0;
   localparam logic [ERC_RAW-1:0] ERC_REG_STATUS = 2'h1;

   // control field positions
   localparam int ERC_CTRL_CLK_LSB = 0;
   localparam int ERC_CTRL_MEM_LSB = 2;
   localparam int ERC_CTRL_SPRDW_LSB = 4;
   localparam int ERC_CTRL_MPDC_BIT = 6;
   localparam int ERC_CTRL_OREGA_BIT = 7;
   localparam int ERC_CTRL_OREGB_BIT = 8;
   localparam int ERC_CTRL_KIND_BIT = 9;
   // single clock, true dual-port, new data, mixed old data, no out regs, block ram
   localparam logic [ERC_CTRL_W-1:0] ERC_CTRL_RST = 10'h003;

   // status field positions
   localparam int ERC_ST_BAD_BIT = 0;
   localparam int ERC_ST_CONFLICT_BIT = 1;
   localparam int ERC_ST_MIXED_BIT = 2;

   // value shown or stored where the result is undefined
   localparam logic [ERC_DW-1:0] ERC_DC_FILL = 16'hffff;
   localparam logic [ERC_DW-1:0] ERC_ZERO_WORD = 16'h0000;
   // memory contents at power-up; replace for a pre-initialised image
   localparam logic [ERC_DEPTH-1:0][ERC_DW-1:0] ERC_MEM_INIT = '0;

   typedef enum logic [1:0] {
      ERC_CLK_INDEP = 2'h0,
      ERC_CLK_INOUT = 2'h1,
      ERC_CLK_RDWR = 2'h2,
      ERC_CLK_SINGLE = 2'h3
   } erc_clk_e;

   typedef enum logic [1:0] {
      ERC_MEM_TDP = 2'h0,
      ERC_MEM_SDP = 2'h1,
      ERC_MEM_SP = 2'h2,
      ERC_MEM_ROM = 2'h3
   } erc_mem_e;

   typedef enum logic [1:0] {
      ERC_SP_NEW = 2'h0,
      ERC_SP_OLD = 2'h1,
      ERC_SP_DC = 2'h2
   } erc_sprdw_e;

   typedef struct packed {
      logic [ERC_CTRL_W-1:0] ctrl;
      logic conflict_seen;
      logic mixed_seen;
      logic [ERC_DW-1:0] rdata;
      logic [ERC_AW-1:0] ra_a;
      logic [ERC_AW-1:0] ra_b;
      logic [ERC_DEPTH-1:0][ERC_DW-1:0] mem;
   } erc_state_s;

   typedef struct packed {
      logic [ERC_DW-1:0] lat;
      logic [ERC_DW-1:0] q;
   } erc_out_s;

   localparam erc_state_s ERC_STATE_RST = '{
      ctrl: ERC_CTRL_RST,
      conflict_seen: 1'b0,
      mixed_seen: 1'b0,
      rdata: ERC_ZERO_WORD,
      ra_a: '0,
      ra_b: '0,
      mem: ERC_MEM_INIT
   };
endpackage

// ===== rtl/erc_ram.sv
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// RULE_01: independent mode: port A logic on enable A, port B on enable B; TDP/ROM only
// RULE_02: independent mode: each port's clock enable gates only that port's registers
// RULE_03: only output latches and output registers have an asynchronous clear
// RULE_04: input/output mode: all input registers on the input clock; TDP, SDP, SP, ROM
// RULE_05: input/output mode: output registers run on a separate output clock
// RULE_06: read/write mode: write data, address, enable on write clock; SDP only
// RULE_07: read/write mode: read side on read clock; each clock has its own enable
// RULE_08: read/write mode: same-address read and write gives unknown read data
// RULE_09: single clock mode: every register on one clock and one enable
// RULE_10: user logic must avoid dual writes to one address; such writes store junk
// RULE_11: same-port new data: read during write shows the data just written
// RULE_12: same-port old data: read during write shows contents before the write
// RULE_13: same-port don't care: read during write may show any value
// RULE_14: mixed-port on a common clock offers only old data or don't care
// RULE_15: mixed-port old data: reader sees contents before the other port's write
// RULE_16: mixed-port read during write across different clocks returns unknown
// RULE_17: block ram outputs are zero at power-up, registered or not
// RULE_18: logic-array ram: zero with output regs, else shows memory at power-up; here reset zeroes every output and the ctrl reset selects block ram
// RULE_19: cells start at the init image; outputs still start cleared
// RULE_20: user logic should drop read enable when read data is not needed
// RULE_21: logic-array ram keeps address registers outside the storage array
// RULE_22: enabling output registers adds exactly one clock of read latency
// RULE_23: with a clock enable low, its registers hold and no access happens
module erc_ram
   import erc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [erc_pkg::ERC_RAW-1:0] reg_addr,
   input wire logic [erc_pkg::ERC_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [erc_pkg::ERC_DW-1:0] reg_rdata,
   input wire logic ce_a,
   input wire logic aclr_a,
   input wire logic [erc_pkg::ERC_AW-1:0] addr_a,
   input wire logic [erc_pkg::ERC_DW-1:0] wdata_a,
   input wire logic [erc_pkg::ERC_BEW-1:0] be_a,
   input wire logic we_a,
   input wire logic re_a,
   output logic [erc_pkg::ERC_DW-1:0] q_a,
   input wire logic ce_b,
   input wire logic aclr_b,
   input wire logic [erc_pkg::ERC_AW-1:0] addr_b,
   input wire logic [erc_pkg::ERC_DW-1:0] wdata_b,
   input wire logic [erc_pkg::ERC_BEW-1:0] be_b,
   input wire logic we_b,
   input wire logic re_b,
   output logic [erc_pkg::ERC_DW-1:0] q_b
);
   import erc_pkg::*;

   erc_state_s st_q;
   erc_state_s st_d;
   erc_out_s oa_q;
   erc_out_s oa_d;
   erc_out_s ob_q;
   erc_out_s ob_d;

   erc_clk_e clk_mode;
   erc_mem_e mem_mode;
   erc_sprdw_e sp_mode;
   logic mp_dc;
   logic oreg_a;
   logic oreg_b;
   logic kind_logic;
   logic cfg_ok;
   logic common_clk;
   logic in_ce_a;
   logic in_ce_b;
   logic out_ce_a;
   logic out_ce_b;
   logic wr_a;
   logic wr_b;
   logic rd_a;
   logic rd_b;
   logic same_addr;
   logic conflict;
   logic mixed_a;
   logic mixed_b;
   logic [ERC_DW-1:0] old_a;
   logic [ERC_DW-1:0] old_b;
   logic [ERC_DW-1:0] merged_a;
   logic [ERC_DW-1:0] merged_b;
   logic [ERC_DW-1:0] rdata_a;
   logic [ERC_DW-1:0] rdata_b;
   logic [ERC_DW-1:0] status_word;

   function automatic logic [ERC_DW-1:0] merge_bytes(
      input logic [ERC_DW-1:0] old_w,
      input logic [ERC_DW-1:0] new_w,
      input logic [ERC_BEW-1:0] be
   );
      logic [ERC_DW-1:0] res;
      res = old_w;
      for (int i = 0; i < ERC_BEW; i++)
      begin
         if (be[i])
         begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // which clocking scheme may carry which memory mode
   function automatic logic mode_legal(input erc_clk_e cm, input erc_mem_e mm);
      logic ok;
      case (cm)
         ERC_CLK_INDEP: ok = (mm == ERC_MEM_TDP) || (mm == ERC_MEM_ROM); // RULE_01
         ERC_CLK_INOUT: ok = 1'b1; // RULE_04
         ERC_CLK_RDWR: ok = (mm == ERC_MEM_SDP); // RULE_06
         ERC_CLK_SINGLE: ok = 1'b1; // RULE_09
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // read result of one port, covering both read-during-write cases
   function automatic logic [ERC_DW-1:0] read_word(
      input logic [ERC_DW-1:0] old_w,
      input logic [ERC_DW-1:0] merged_w,
      input logic own_wr,
      input logic cross_wr,
      input logic cross_ok,
      input logic clash,
      input erc_sprdw_e spm
   );
      logic [ERC_DW-1:0] res;
      res = old_w;
      if (own_wr)
      begin
         case (spm)
            ERC_SP_NEW: res = clash ? ERC_DC_FILL : merged_w; // RULE_11
            ERC_SP_OLD: res = old_w; // RULE_12
            default: res = ERC_DC_FILL; // RULE_13
         endcase
      end
      else if (cross_wr)
      begin
         // no new-data choice here: old contents or the fill value
         res = cross_ok ? old_w : ERC_DC_FILL; // RULE_14 RULE_15 RULE_16 RULE_08
      end
      return res;
   endfunction

   always_comb
   begin
      clk_mode = erc_clk_e'(st_q.ctrl[ERC_CTRL_CLK_LSB +: 2]);
      mem_mode = erc_mem_e'(st_q.ctrl[ERC_CTRL_MEM_LSB +: 2]);
      sp_mode = erc_sprdw_e'(st_q.ctrl[ERC_CTRL_SPRDW_LSB +: 2]);
      mp_dc = st_q.ctrl[ERC_CTRL_MPDC_BIT];
      oreg_a = st_q.ctrl[ERC_CTRL_OREGA_BIT];
      oreg_b = st_q.ctrl[ERC_CTRL_OREGB_BIT];
      kind_logic = st_q.ctrl[ERC_CTRL_KIND_BIT];
      cfg_ok = mode_legal(clk_mode, mem_mode);
      common_clk = (clk_mode == ERC_CLK_SINGLE) || (clk_mode == ERC_CLK_INOUT);

      // the single clk stands in for every port clock; enables pick the domain
      in_ce_a = ce_a; // RULE_01 RULE_04 RULE_06 RULE_09
      in_ce_b = common_clk ? ce_a : ce_b; // RULE_02 RULE_07 RULE_09
      out_ce_a = (clk_mode == ERC_CLK_INOUT) ? ce_b : ce_a; // RULE_05
      out_ce_b = (clk_mode == ERC_CLK_SINGLE) ? ce_a : ce_b; // RULE_05 RULE_07

      // port roles per memory mode; an illegal pairing freezes the array
      wr_a = cfg_ok && in_ce_a && we_a && (mem_mode != ERC_MEM_ROM); // RULE_23
      wr_b = cfg_ok && in_ce_b && we_b && (mem_mode == ERC_MEM_TDP); // RULE_23
      // read enable low skips the read and keeps the output latches still
      rd_a = cfg_ok && in_ce_a && re_a && (mem_mode != ERC_MEM_SDP); // RULE_20
      rd_b = cfg_ok && in_ce_b && re_b && (mem_mode != ERC_MEM_SP); // RULE_20

      same_addr = (addr_a == addr_b);
      conflict = wr_a && wr_b && same_addr;
      mixed_a = rd_a && wr_b && same_addr;
      mixed_b = rd_b && wr_a && same_addr;

      old_a = st_q.mem[addr_a];
      old_b = st_q.mem[addr_b];
      merged_a = merge_bytes(old_a, wdata_a, be_a);
      merged_b = merge_bytes(old_b, wdata_b, be_b);
      rdata_a = read_word(old_a, merged_a, wr_a && rd_a, mixed_a,
                          common_clk && !mp_dc, conflict, sp_mode);
      rdata_b = read_word(old_b, merged_b, wr_b && rd_b, mixed_b,
                          common_clk && !mp_dc, conflict, sp_mode);

      status_word = ERC_ZERO_WORD;
      status_word[ERC_ST_BAD_BIT] = !cfg_ok;
      status_word[ERC_ST_CONFLICT_BIT] = st_q.conflict_seen;
      status_word[ERC_ST_MIXED_BIT] = st_q.mixed_seen;

      st_d = st_q;
      oa_d = oa_q;
      ob_d = ob_q;

      // storage update; no arbitration, a dual write leaves junk behind
      if (conflict)
      begin
         st_d.mem[addr_a] = ERC_DC_FILL; // RULE_10
      end
      else
      begin
         if (wr_a)
         begin
            st_d.mem[addr_a] = merged_a;
         end
         if (wr_b)
         begin
            st_d.mem[addr_b] = merged_b;
         end
      end

      // address registers sit beside the array, gated by the input enable
      if (in_ce_a)
      begin
         st_d.ra_a = addr_a; // RULE_21
      end
      if (in_ce_b)
      begin
         st_d.ra_b = addr_b; // RULE_21
      end

      // output latch on the access edge, optional register on the output enable
      if (rd_a)
      begin
         oa_d.lat = rdata_a;
      end
      if (oreg_a)
      begin
         if (out_ce_a)
         begin
            oa_d.q = oa_q.lat; // RULE_22
         end
      end
      else if (kind_logic)
      begin
         // unregistered logic-array output follows the stored word
         oa_d.q = st_d.mem[st_d.ra_a]; // RULE_18
      end
      else if (rd_a)
      begin
         oa_d.q = rdata_a;
      end

      if (rd_b)
      begin
         ob_d.lat = rdata_b;
      end
      if (oreg_b)
      begin
         if (out_ce_b)
         begin
            ob_d.q = ob_q.lat; // RULE_22
         end
      end
      else if (kind_logic)
      begin
         ob_d.q = st_d.mem[st_d.ra_b]; // RULE_18
      end
      else if (rd_b)
      begin
         ob_d.q = rdata_b;
      end

      // sticky events; an event in the clearing cycle still sets the bit
      if (reg_wr && reg_addr == ERC_REG_CTRL)
      begin
         st_d.ctrl = reg_wdata[ERC_CTRL_W-1:0];
      end
      if (reg_wr && reg_addr == ERC_REG_STATUS)
      begin
         st_d.conflict_seen = st_q.conflict_seen && !reg_wdata[ERC_ST_CONFLICT_BIT];
         st_d.mixed_seen = st_q.mixed_seen && !reg_wdata[ERC_ST_MIXED_BIT];
      end
      if (conflict)
      begin
         st_d.conflict_seen = 1'b1;
      end
      if (!common_clk && (mixed_a || mixed_b))
      begin
         st_d.mixed_seen = 1'b1;
      end

      if (reg_rd)
      begin
         case (reg_addr)
            ERC_REG_CTRL: st_d.rdata = {{(ERC_DW-ERC_CTRL_W){1'b0}}, st_q.ctrl};
            ERC_REG_STATUS: st_d.rdata = status_word;
            default: st_d.rdata = ERC_ZERO_WORD;
         endcase
      end
   end

   // array, control and address registers: no clear beyond power-up reset
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q <= ERC_STATE_RST; // RULE_19
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // only the output latch and register of each port take the async clear
   always_ff @(posedge clk or negedge reset_n or posedge aclr_a)
   begin
      if (!reset_n)
      begin
         oa_q <= '0; // RULE_17
      end
      else if (aclr_a)
      begin
         oa_q <= '0; // RULE_03
      end
      else
      begin
         oa_q <= oa_d;
      end
   end

   always_ff @(posedge clk or negedge reset_n or posedge aclr_b)
   begin
      if (!reset_n)
      begin
         ob_q <= '0; // RULE_17
      end
      else if (aclr_b)
      begin
         ob_q <= '0; // RULE_03
      end
      else
      begin
         ob_q <= ob_d;
      end
   end

   assign q_a = oa_q.q;
   assign q_b = ob_q.q;
   assign reg_rdata = st_q.rdata;

   sequence s_reg_read_b;
      (rd_b && oreg_b) ##1 (out_ce_b && oreg_b);
   endsequence

   sequence s_own_new_a;
      wr_a && rd_a && sp_mode == ERC_SP_NEW && !conflict;
   endsequence

   a_new_data_a: assert property (@(posedge clk) disable iff (!reset_n || aclr_a) // RULE_11
      s_own_new_a |=> oa_q.lat == $past(merged_a))
      else $error("new-data read did not return the written word");

   a_old_data_a: assert property (@(posedge clk) disable iff (!reset_n || aclr_a) // RULE_12
      (wr_a && rd_a && sp_mode == ERC_SP_OLD) |=> oa_q.lat == $past(old_a))
      else $error("old-data read did not return the previous word");

   a_mixed_old_b: assert property (@(posedge clk) disable iff (!reset_n || aclr_b) // RULE_15
      (mixed_b && !wr_b && common_clk && !mp_dc) |=> ob_q.lat == $past(old_b))
      else $error("mixed-port old-data read returned the wrong word");

   a_cross_unknown_b: assert property (@(posedge clk) disable iff (!reset_n || aclr_b) // RULE_16
      (mixed_b && !wr_b && !common_clk) |=> ob_q.lat == ERC_DC_FILL && st_q.mixed_seen)
      else $error("cross-clock read during write not flagged as unknown");

   a_out_delay_b: assert property (@(posedge clk) disable iff (!reset_n || aclr_b) // RULE_22
      s_reg_read_b |=> ob_q.q == $past(rdata_b, 2))
      else $error("registered output not one extra cycle behind the read");

   a_out_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
      aclr_a |-> oa_q == '0 && q_a == ERC_ZERO_WORD)
      else $error("output clear did not zero port A outputs");

   a_powerup_zero: assert property (@(posedge clk) // RULE_17
      $rose(reset_n) |-> q_a == ERC_ZERO_WORD && q_b == ERC_ZERO_WORD)
      else $error("outputs not cleared at power-up");

   a_hold_noce: assert property (@(posedge clk) disable iff (!reset_n) // RULE_23
      (!ce_a && !ce_b) |=> $stable(st_q.mem) && $stable(st_q.ra_a))
      else $error("memory changed with both clock enables low");

   a_illegal_freeze: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
      !cfg_ok |=> $stable(st_q.mem))
      else $error("memory written under an unsupported mode pairing");

   a_indep_gate_b: assert property (@(posedge clk) disable iff (!reset_n || aclr_b) // RULE_02
      (clk_mode == ERC_CLK_INDEP && !ce_b && !kind_logic) |=> $stable(ob_q))
      else $error("port B output moved with its enable low");

   a_conflict_flag: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
      conflict |=> st_q.conflict_seen && st_q.mem[$past(addr_a)] == ERC_DC_FILL)
      else $error("dual write not flagged or not filled");
endmodule

// ===== tb/erc_user.sv
`timescale 1ns/100ps
// user logic on the far side of both ram ports
module erc_user
   import erc_pkg::*;
(
   input wire logic clk,
   output logic ce_a,
   output logic aclr_a,
   output logic [erc_pkg::ERC_AW-1:0] addr_a,
   output logic [erc_pkg::ERC_DW-1:0] wdata_a,
   output logic [erc_pkg::ERC_BEW-1:0] be_a,
   output logic we_a,
   output logic re_a,
   output logic ce_b,
   output logic aclr_b,
   output logic [erc_pkg::ERC_AW-1:0] addr_b,
   output logic [erc_pkg::ERC_DW-1:0] wdata_b,
   output logic [erc_pkg::ERC_BEW-1:0] be_b,
   output logic we_b,
   output logic re_b
);
   // set only by a scenario that wants a dual write to one address
   logic clash_ok;

   initial
   begin
      clash_ok = 1'b0;
      {ce_a, aclr_a, addr_a, wdata_a, be_a, we_a, re_a} = '0;
      {ce_b, aclr_b, addr_b, wdata_b, be_b, we_b, re_b} = '0;
   end

   // one request per port, launched after an edge, sampled at the next
   task automatic req(input logic [1:0] ce, input logic [1:0] we, input logic [1:0] re,
      input logic [ERC_AW-1:0] aa, input logic [ERC_AW-1:0] ab,
      input logic [ERC_DW-1:0] da, input logic [ERC_DW-1:0] db,
      input logic [ERC_BEW-1:0] ea, input logic [ERC_BEW-1:0] eb);
      @(posedge clk);
      ce_a <= ce[0];
      ce_b <= ce[1];
      we_a <= we[0];
      we_b <= we[1] && (clash_ok || !we[0] || aa != ab);
      re_a <= re[0];
      re_b <= re[1];
      // unused lines toggle so a stale value can never pass for a real one
      addr_a <= (we[0] || re[0]) ? aa : ~addr_a;
      addr_b <= (we[1] || re[1]) ? ab : ~addr_b;
      wdata_a <= we[0] ? da : ~wdata_a;
      wdata_b <= we[1] ? db : ~wdata_b;
      be_a <= we[0] ? ea : ~be_a;
      be_b <= we[1] ? eb : ~be_b;
   endtask

   task automatic clear_a();
      @(posedge clk);
      aclr_a <= 1'b1;
      @(posedge clk);
      aclr_a <= 1'b0;
   endtask
endmodule

// ===== tb/embedded_ram_clocking_rdw_test.sv
`timescale 1ns/100ps
module embedded_ram_clocking_rdw_test;
   import erc_pkg::*;
   logic clk;
   logic reset_n;
   logic [ERC_RAW-1:0] reg_addr;
   logic [ERC_DW-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [ERC_DW-1:0] reg_rdata;
   logic ce_a, aclr_a, we_a, re_a, ce_b, aclr_b, we_b, re_b;
   logic [ERC_AW-1:0] addr_a, addr_b, a;
   logic [ERC_DW-1:0] wdata_a, wdata_b, q_a, q_b, d, old, rv;
   logic [ERC_BEW-1:0] be_a, be_b, be;
   logic [ERC_DW-1:0] mem_exp [ERC_DEPTH];
   int n_errors;
   int samples_checked;
   int cycles;

   erc_ram i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ce_a(ce_a), .aclr_a(aclr_a),
      .addr_a(addr_a), .wdata_a(wdata_a), .be_a(be_a), .we_a(we_a), .re_a(re_a), .q_a(q_a),
      .ce_b(ce_b), .aclr_b(aclr_b), .addr_b(addr_b), .wdata_b(wdata_b), .be_b(be_b),
      .we_b(we_b), .re_b(re_b), .q_b(q_b));

   erc_user i_user (.clk(clk), .ce_a(ce_a), .aclr_a(aclr_a), .addr_a(addr_a),
      .wdata_a(wdata_a), .be_a(be_a), .we_a(we_a), .re_a(re_a), .ce_b(ce_b), .aclr_b(aclr_b),
      .addr_b(addr_b), .wdata_b(wdata_b), .be_b(be_b), .we_b(we_b), .re_b(re_b));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [ERC_DW-1:0] ctrl_of(input logic [1:0] ck, input logic [1:0] mm,
      input logic [1:0] sp, input logic mp, input logic oa);
      return {8'h00, oa, mp, sp, mm, ck};
   endfunction

   function automatic logic legal(input logic [1:0] ck, input logic [1:0] mm);
      case (ck)
         2'h0: return mm == 2'h0 || mm == 2'h3;
         2'h2: return mm == 2'h1;
         default: return 1'b1;
      endcase
   endfunction

   function automatic logic [ERC_DW-1:0] merge(input logic [ERC_DW-1:0] o,
      input logic [ERC_DW-1:0] n, input logic [ERC_BEW-1:0] e);
      return {e[1] ? n[15:8] : o[15:8], e[0] ? n[7:0] : o[7:0]};
   endfunction

   task automatic print_verdict();
      if (n_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [ERC_DW-1:0] exp,
      input logic [ERC_DW-1:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask

   task automatic reg_write(input logic [ERC_RAW-1:0] ad, input logic [ERC_DW-1:0] wd);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= wd;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [ERC_RAW-1:0] ad, output logic [ERC_DW-1:0] rd);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask

   task automatic idle();
      i_user.req(2'b11, 2'b00, 2'b00, '0, '0, '0, '0, 2'b00, 2'b00);
      #1;
   endtask

   // one access cycle, then outputs are looked at one edge later
   task automatic op(input logic [1:0] ce, input logic [1:0] we, input logic [1:0] re,
      input logic [ERC_AW-1:0] aa, input logic [ERC_AW-1:0] ab,
      input logic [ERC_DW-1:0] da, input logic [ERC_DW-1:0] db);
      i_user.req(ce, we, re, aa, ab, da, db, be, 2'b11);
      idle();
   endtask

   task automatic status_is(input logic [ERC_DW-1:0] mask, input logic [ERC_DW-1:0] exp);
      reg_read(ERC_REG_STATUS, rv);
      check("status", exp, rv & mask);
      reg_write(ERC_REG_STATUS, mask);
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   initial
   begin
      reset_n = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {n_errors, samples_checked, cycles} = '0;
      be = 2'b11;
      foreach (mem_exp[i]) mem_exp[i] = ERC_ZERO_WORD;
      void'($urandom(54));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      check("q_a at reset", ERC_ZERO_WORD, q_a);
      check("q_b at reset", ERC_ZERO_WORD, q_b);
      reg_read(ERC_REG_CTRL, rv);
      check("ctrl reset", 16'h0003, rv);
      reg_read(2'h2, rv);
      check("unmapped read", ERC_ZERO_WORD, rv);
      for (int c = 0; c < 4; c++)
         for (int m = 0; m < 4; m++)
         begin
            reg_write(ERC_REG_CTRL, ctrl_of(2'(c), 2'(m), ERC_SP_NEW, 1'b0, 1'b0));
            reg_read(ERC_REG_STATUS, rv);
            check("pairing flag", {15'h0000, !legal(2'(c), 2'(m))}, rv & 16'h0001);
         end
      reg_write(ERC_REG_CTRL, ctrl_of(ERC_CLK_SINGLE, ERC_MEM_TDP, ERC_SP_NEW, 1'b0, 1'b0));
      for (int i = 0; i < 10; i++)
      begin
         a = (i < 2) ? ERC_AW'(i * 63) : ERC_AW'($urandom);
         d = ERC_DW'($urandom);
         be = (i == 0) ? 2'b01 : 2'($urandom % 3 + 1);
         mem_exp[a] = merge(mem_exp[a], d, be);
         op(2'b11, 2'b01, 2'b01, a, a, d, d);
         check("q_a new data", mem_exp[a], q_a);
      end
      be = 2'b11;
      a = ERC_AW'($urandom);
      old = mem_exp[a];
      op(2'b00, 2'b01, 2'b00, a, a, ~old, ~old);
      op(2'b11, 2'b00, 2'b01, a, a, old, old);
      check("q_a after gated write", old, q_a);
      for (int m = 1; m < 3; m++)
      begin
         reg_write(ERC_REG_CTRL, ctrl_of(ERC_CLK_SINGLE, ERC_MEM_TDP, 2'(m), 1'b0, 1'b0));
         a = ERC_AW'($urandom);
         old = mem_exp[a];
         mem_exp[a] = ~old;
         op(2'b11, 2'b01, 2'b01, a, a, ~old, ~old);
         check("q_a same port", (m == 1) ? old : ERC_DC_FILL, q_a);
      end
      for (int m = 0; m < 2; m++)
      begin
         reg_write(ERC_REG_CTRL, ctrl_of(ERC_CLK_SINGLE, ERC_MEM_TDP, ERC_SP_NEW, m[0], 1'b0));
         a = ERC_AW'($urandom);
         old = mem_exp[a];
         mem_exp[a] = ~old;
         op(2'b11, 2'b01, 2'b10, a, a, ~old, ~old);
         check("q_b mixed port", (m == 0) ? old : ERC_DC_FILL, q_b);
         op(2'b11, 2'b00, 2'b10, a, a, old, old);
         check("q_b read back", mem_exp[a], q_b);
      end
      for (int m = 0; m < 2; m++)
      begin
         if (m == 0)
            reg_write(ERC_REG_CTRL, ctrl_of(ERC_CLK_INDEP, ERC_MEM_TDP, ERC_SP_NEW, 1'b0, 1'b0));
         else
            reg_write(ERC_REG_CTRL, ctrl_of(ERC_CLK_RDWR, ERC_MEM_SDP, ERC_SP_NEW, 1'b0, 1'b0));
         a = ERC_AW'($urandom);
         d = ERC_DW'($urandom);
         mem_exp[a] = d;
         op(2'b11, 2'b01, 2'b10, a, a, d, d);
         check("q_b cross clock", ERC_DC_FILL, q_b);
         status_is(16'h0004, 16'h0004);
         status_is(16'h0004, ERC_ZERO_WORD);
      end
      reg_write(ERC_REG_CTRL, ctrl_of(ERC_CLK_INDEP, ERC_MEM_TDP, ERC_SP_NEW, 1'b0, 1'b0));
      a = ERC_AW'($urandom);
      old = mem_exp[a ^ 6'h01];
      d = ERC_DW'($urandom);
      mem_exp[a] = d;
      op(2'b01, 2'b11, 2'b01, a, a ^ 6'h01, d, ~old);
      check("q_a port a alone", d, q_a);
      op(2'b11, 2'b00, 2'b10, a, a ^ 6'h01, d, d);
      check("q_b after gated port", old, q_b);
      reg_write(ERC_REG_CTRL, ctrl_of(ERC_CLK_SINGLE, ERC_MEM_TDP, ERC_SP_NEW, 1'b0, 1'b0));
      i_user.clash_ok = 1'b1;
      a = ERC_AW'($urandom);
      d = ERC_DW'($urandom);
      mem_exp[a] = ERC_DC_FILL;
      op(2'b11, 2'b11, 2'b00, a, a, d, ~d);
      i_user.clash_ok = 1'b0;
      op(2'b11, 2'b00, 2'b01, a, a, d, d);
      check("q_a after clash", ERC_DC_FILL, q_a);
      status_is(16'h0002, 16'h0002);
      // both output registers on, so port B's registered path is exercised too
      rv = ctrl_of(ERC_CLK_SINGLE, ERC_MEM_TDP, ERC_SP_NEW, 1'b0, 1'b1) | 16'h0100;
      reg_write(ERC_REG_CTRL, rv);
      i_user.clear_a();
      #1;
      check("q_a after clear", ERC_ZERO_WORD, q_a);
      a = ERC_AW'($urandom);
      old = mem_exp[a];
      d = ERC_DW'($urandom);
      mem_exp[a] = d;
      op(2'b11, 2'b01, 2'b11, a, a, d, d);
      check("q_a one edge", ERC_ZERO_WORD, q_a);
      idle();
      check("q_a two edges", d, q_a);
      check("q_b two edges", old, q_b);
      // output enable of port A follows ce_b here, so a low ce_b holds q_a
      reg_write(ERC_REG_CTRL, ctrl_of(ERC_CLK_INOUT, ERC_MEM_TDP, ERC_SP_NEW, 1'b0, 1'b1));
      old = d;
      a = ERC_AW'($urandom);
      d = ERC_DW'($urandom);
      mem_exp[a] = d;
      op(2'b01, 2'b01, 2'b01, a, a, d, d);
      check("q_a output enable low", old, q_a);
      idle();
      check("q_a output enable high", d, q_a);
      // logic-array kind without output register shows the stored word, no read needed
      rv = ctrl_of(ERC_CLK_SINGLE, ERC_MEM_TDP, ERC_SP_NEW, 1'b0, 1'b0) | 16'h0200;
      reg_write(ERC_REG_CTRL, rv);
      a = ERC_AW'($urandom);
      d = ERC_DW'($urandom);
      mem_exp[a] = d;
      op(2'b11, 2'b01, 2'b00, a, a, d, d);
      check("q_a logic ram follows", d, q_a);
      print_verdict();
   end
endmodule
